/* logic/fbrp_port.sv */
// read side of the flash host interface: identification, async and wrapping burst reads
`timescale 1ns/10ps
`include "fbrp_params.svh"
module fbrp_port
  import fbrp_pkg::*;
#(
  parameter int AW = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // host pins
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic address_valid_n,
  input wire logic wide_bus,
  input wire logic [AW-1:0] address,
  input wire logic half_word_addr,
  input wire logic id_high_voltage,
  // configuration and mode, from the command logic
  input wire logic cfg_write,
  input wire fbrp_cfg_t cfg_in,
  input wire logic id_mode,
  input wire logic [1:0] id_select,
  input wire logic sector_protected,
  input wire fbrp_space_t space,
  // array read port, combinational lookup by word address
  output logic [AW:0] array_addr,
  input wire logic [31:0] array_data,
  input wire logic [31:0] single_data,
  // data and indicator pins
  output logic [31:0] dq_out,
  output logic [31:0] dq_oe,
  output logic end_of_burst_n_out,
  output logic end_of_burst_n_oe,
  // status
  output fbrp_cfg_t cfg_q,
  output logic burst_active
);
  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [4:0] s1_q, s2_q;
  logic [AW:0] a1_q, a2_q;
  // reset to the idle pin levels, so no false address-valid edge or id voltage follows reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_q <= `FBRP_PIN_IDLE;
      s2_q <= `FBRP_PIN_IDLE;
    end
    else
    begin
      s1_q <= {chip_select_n, output_enable_n, address_valid_n, wide_bus, id_high_voltage};
      s2_q <= s1_q;
    end
  end
  // address pins get the same two stages so they line up with address-valid
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      a1_q <= '0;
      a2_q <= '0;
    end
    else
    begin
      a1_q <= {address, half_word_addr};
      a2_q <= a1_q;
    end
  end
  wire cs_n = s2_q[4];
  wire oe_n = s2_q[3];
  wire adv_n = s2_q[2];
  wire wide = s2_q[1];
  wire hv = s2_q[0];
  // half-word bit is the lsb of the word address in 16-bit mode
  wire [AW:0] waddr = wide ? {1'b0, a2_q[AW:1]} : a2_q;
  ////////////////////////////////////////////////////////////////////////////////
  // configuration
  // reset clears to asynchronous mode; latency values out of range are clamped
  wire [4:0] lat_in = (cfg_in.latency < `FBRP_LAT_MIN) ? `FBRP_LAT_MIN :
                      (cfg_in.latency > `FBRP_LAT_MAX) ? `FBRP_LAT_MAX : cfg_in.latency;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      cfg_q <= '{burst_en: 1'b0, length: `FBRP_BL_4, latency: `FBRP_LAT_MIN};
    else if (cfg_write)
      cfg_q <= '{burst_en: cfg_in.burst_en, length: cfg_in.length, latency: lat_in};
  end
  ////////////////////////////////////////////////////////////////////////////////
  // burst length decode
  function automatic logic [4:0] len_mask(input logic [2:0] l, input logic w);
    logic [4:0] m;
    m = 5'h03;
    case (l)
      `FBRP_BL_2: m = w ? 5'h01 : 5'h03;
      `FBRP_BL_4: m = 5'h03;
      `FBRP_BL_8: m = 5'h07;
      `FBRP_BL_16: m = 5'h0f;
      `FBRP_BL_32: m = 5'h1f;
      default: m = 5'h03;
    endcase
    return m;
  endfunction : len_mask
  // lengths 16 and 32 exist only on the 16-bit bus; the wide bus falls back to 8
  wire [2:0] eff_len = (wide && cfg_q.length > `FBRP_BL_8) ? `FBRP_BL_8 : cfg_q.length;
  // x32 counts doublewords; only length 2 differs, with two reads on x32 against four on x16
  wire [4:0] mask = len_mask(eff_len, wide);
  ////////////////////////////////////////////////////////////////////////////////
  // burst sequencer
  typedef enum logic [1:0] {fbrp_idle, fbrp_wait, fbrp_run} fbrp_state_t;
  fbrp_state_t st_q, st_d;
  logic [AW:0] base_q;
  logic [4:0] pos_q, start_q, lat_q;
  logic [8:0] otp_cnt_q;
  logic adv_n_q;
  // a low address-valid sampled at an edge, or its rising edge, starts a burst
  wire adv_low = !adv_n;
  wire adv_rise = adv_n && !adv_n_q;
  wire start = !cs_n && (adv_low || adv_rise) && st_q != fbrp_wait;
  wire is_burst = cfg_q.burst_en && (space == fbrp_rd_array || space == fbrp_rd_otp);
  wire capture = start && is_burst;
  wire [4:0] pos_next = (pos_q & ~mask) | ((pos_q + 5'h01) & mask);
  wire last = ((pos_next & mask) == (start_q & mask));
  wire beat_ok;
  wire beat_push = (st_q == fbrp_run) && beat_ok;
  wire [8:0] otp_step = wide ? 9'h004 : 9'h002;
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      fbrp_idle:
      begin
        if (capture)
          st_d = fbrp_wait;
      end
      fbrp_wait:
      begin
        if (lat_q == 5'h01)
          st_d = fbrp_run;
      end
      fbrp_run:
      begin
        // a fresh address-valid pulse drops the running burst and starts over
        if (capture)
          st_d = fbrp_wait;
      end
      default:
      begin
        st_d = fbrp_idle;
      end
    endcase
    if (cs_n)
      st_d = fbrp_idle;
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= fbrp_idle;
      adv_n_q <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      adv_n_q <= adv_n;
    end
  end
  // base and start position are held for the whole burst so it can wrap
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      base_q <= '0;
      start_q <= '0;
    end
    else if (capture)
    begin
      base_q <= waddr;
      start_q <= waddr[4:0];
    end
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pos_q <= '0;
    else if (capture)
      pos_q <= waddr[4:0];
    else if (beat_push)
      pos_q <= pos_next;
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      lat_q <= '0;
    else if (capture)
      lat_q <= cfg_q.latency - 5'h01;
    else if (st_q == fbrp_wait)
      lat_q <= lat_q - 5'h01;
  end
  // saturates at the sector size; a bus width change mid-burst can step two bytes past the limit
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      otp_cnt_q <= '0;
    else if (capture)
      otp_cnt_q <= '0;
    else if (beat_push && otp_cnt_q < `FBRP_OTP_BYTES)
      otp_cnt_q <= otp_cnt_q + otp_step;
  end
  assign burst_active = (st_q != fbrp_idle);
  assign array_addr = burst_active ? {base_q[AW:5], pos_q} : waddr;
  ////////////////////////////////////////////////////////////////////////////////
  // read data selection
  function automatic logic [31:0] id_code(input logic [1:0] s, input logic p);
    logic [31:0] c;
    c = 32'h00000000;
    case (s)
      `FBRP_ID_SEL_MAKER: c = {24'h000000, `FBRP_ID_MAKER};
      `FBRP_ID_SEL_PART: c = {24'h000000, `FBRP_ID_PART};
      `FBRP_ID_SEL_PROT: c = {31'h00000000, p};
      default: c = 32'h00000000;
    endcase
    return c;
  endfunction : id_code
  // is the host's job; high voltage on A9 and the ID command both reach here
  wire ident = id_mode || hv || space == fbrp_rd_ident;
  wire otp_over = (space == fbrp_rd_otp) && (otp_cnt_q >= `FBRP_OTP_BYTES);
  wire [31:0] rd_word = ident ? id_code(id_select, sector_protected) :
                        (space == fbrp_rd_single) ? single_data :
                        otp_over ? 32'hffffffff : array_data;
  wire [31:0] rd_bus = wide ? rd_word : {16'h0000, rd_word[15:0]};
  ////////////////////////////////////////////////////////////////////////////////
  // beat FIFO between the sequencer and the pins; draining stops while output is off
  fbrp_beat_t in_beat, out_beat;
  logic out_valid;
  assign in_beat = '{last: last, data: rd_bus};
  wire drain = !oe_n;
  fbrp_fifo #(.WIDTH($bits(fbrp_beat_t)), .DEPTH(`FBRP_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .flush(cs_n || start),
    .in_valid(st_q == fbrp_run),
    .in_ready(beat_ok),
    .in_data(in_beat),
    .out_valid(out_valid),
    .out_ready(drain),
    .out_data(out_beat)
  );
  // sequencing stalls only when the FIFO is full, so output-enable gaps of up to four beats are absorbed
  ////////////////////////////////////////////////////////////////////////////////
  // output registers
  logic [31:0] dq_q;
  logic eob_q, drv_q, eob_drv_q;
  wire en = !cs_n && !oe_n;
  // an enabled burst beat stands on the pins for one clock
  wire beat_out = burst_active && out_valid;
  wire beat_last = beat_out && out_beat.last;
  // with bursts on, an array read waiting for its burst drives nothing, not a stray async word
  wire async_out = !burst_active && !is_burst;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      drv_q <= 1'b0;
      eob_drv_q <= 1'b0;
    end
    else
    begin
      drv_q <= en && (beat_out || async_out);
      eob_drv_q <= en && beat_last;
    end
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      eob_q <= 1'b1;
    else
      eob_q <= !beat_last;
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      dq_q <= '0;
    else if (beat_out)
      dq_q <= out_beat.data;
    else if (!burst_active)
      dq_q <= rd_bus; // async and single reads follow the address while enabled
  end
  assign dq_out = dq_q;
  assign dq_oe = {{16{drv_q && wide}}, {16{drv_q}}};
  assign end_of_burst_n_out = eob_q;
  assign end_of_burst_n_oe = eob_drv_q;
endmodule : fbrp_port
////////////////////////////////////////////////////////////////////////////////
// small flip-flop FIFO for burst beats
module fbrp_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else if (flush)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      if (pop)
        rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // storage needs no reset: the count guards every read
  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wp_q] <= in_data;
  end
endmodule : fbrp_fifo

/* logic/fbrp_params.svh */
// constants for the flash burst read port
`ifndef FBRP_PARAMS_SVH
`define FBRP_PARAMS_SVH
`define FBRP_LAT_MIN 5'h02
`define FBRP_LAT_MAX 5'h10
`define FBRP_OTP_BYTES 9'h100
`define FBRP_BL_2 3'h0
`define FBRP_BL_4 3'h1
`define FBRP_BL_8 3'h2
`define FBRP_BL_16 3'h3
`define FBRP_BL_32 3'h4
`define FBRP_ID_MAKER 8'h5a
`define FBRP_ID_PART 8'h3c
`define FBRP_ID_SEL_MAKER 2'h0
`define FBRP_ID_SEL_PART 2'h1
`define FBRP_ID_SEL_PROT 2'h2
`define FBRP_FIFO_DEPTH 4
// idle pin levels after reset: strobes high, narrow bus, no high voltage
`define FBRP_PIN_IDLE 5'h1c
`endif

/* logic/fbrp_pkg.sv */
// types shared by the flash burst read port
package fbrp_pkg;
  typedef enum logic [1:0] {fbrp_rd_array, fbrp_rd_ident, fbrp_rd_single, fbrp_rd_otp} fbrp_space_t;
  typedef struct packed {
    logic burst_en;
    logic [2:0] length;
    logic [4:0] latency;
  } fbrp_cfg_t;
  typedef struct packed {
    logic last;
    logic [31:0] data;
  } fbrp_beat_t;
endpackage : fbrp_pkg

/* logic/fbrp_fifo.sv */
// beat FIFO: its module is kept in fbrp_port.sv, beside the rest of the port logic

/* tb/fbrp_asserts.sv */
// pin-level checks for the flash burst read port
`timescale 1ns/10ps
module fbrp_asserts
  import fbrp_pkg::*;
#(
  parameter int AW = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // host pins and configuration
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic wide_bus,
  input wire logic [AW-1:0] address,
  input wire logic cfg_write,
  input wire fbrp_cfg_t cfg_in,
  // outputs
  input wire logic [AW:0] array_addr,
  input wire logic [31:0] dq_oe,
  input wire logic end_of_burst_n_out,
  input wire logic end_of_burst_n_oe,
  input wire fbrp_cfg_t cfg_q,
  input wire logic burst_active
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  ////////////////////
  a_cs_float: assert property (chip_select_n [*5] |-> dq_oe == 32'h0 && !end_of_burst_n_oe)
    else $error("pins driven while deselected");
  a_oe_float: assert property (output_enable_n [*5] |-> dq_oe == 32'h0 && !end_of_burst_n_oe)
    else $error("pins driven while output disabled");
  a_eob_low_only: assert property (end_of_burst_n_oe |-> !end_of_burst_n_out)
    else $error("indicator driven high");
  a_eob_one_clk: assert property (end_of_burst_n_oe |=> !end_of_burst_n_oe)
    else $error("indicator held over two clocks");
  a_eob_with_data: assert property (end_of_burst_n_oe |-> dq_oe[0])
    else $error("indicator without a data transfer");
  a_reset_cfg: assert property ($rose(reset_n) |-> cfg_q == 9'h022)
    else $error("configuration not at default after reset");
  a_cfg_load: assert property (cfg_write |=> cfg_q.burst_en == $past(cfg_in.burst_en)
    && cfg_q.length == $past(cfg_in.length))
    else $error("configuration not loaded");
  a_lat_load: assert property (cfg_write && cfg_in.latency inside {[5'h02:5'h10]}
    |=> cfg_q.latency == $past(cfg_in.latency))
    else $error("latency not loaded");
  a_x16_upper: assert property (!wide_bus [*5] |-> dq_oe[31:16] == 16'h0)
    else $error("upper half driven on narrow bus");
  // only judged once the pins have been still long enough that no new start can be in flight
  a_group_fixed: assert property (burst_active && $past(burst_active) && address == $past(address, 4)
    |-> array_addr[AW:5] == $past(array_addr[AW:5]))
    else $error("burst moved outside its group");
endmodule : fbrp_asserts

bind fbrp_port fbrp_asserts #(.AW(AW)) i_fbrp_asserts (.clk(clk), .reset_n(reset_n),
  .chip_select_n(chip_select_n), .output_enable_n(output_enable_n), .wide_bus(wide_bus),
  .address(address), .cfg_write(cfg_write), .cfg_in(cfg_in), .array_addr(array_addr), .dq_oe(dq_oe),
  .end_of_burst_n_out(end_of_burst_n_out), .end_of_burst_n_oe(end_of_burst_n_oe), .cfg_q(cfg_q),
  .burst_active(burst_active));

/* tb/fbrp_host.sv */
// host controller model driving select, output enable, address-valid and address
`timescale 1ns/10ps
module fbrp_host #(
  parameter int AW = 20
) (
  // clock
  input wire logic clk,
  // host pins
  output logic chip_select_n,
  output logic output_enable_n,
  output logic address_valid_n,
  output logic [AW-1:0] address,
  output logic half_word_addr
);
  initial
  begin
    chip_select_n = 1'b1;
    output_enable_n = 1'b1;
    address_valid_n = 1'b1;
    {address, half_word_addr} = '0;
  end
  // address is spoiled once held past capture, so a late capture shows up as bad data
  task automatic start(input logic [AW:0] wa);
    @(posedge clk);
    chip_select_n <= 1'b0;
    output_enable_n <= 1'b0;
    address_valid_n <= 1'b0;
    {address, half_word_addr} <= wa;
    @(posedge clk);
    address_valid_n <= 1'b1;
    repeat (3) @(posedge clk);
    {address, half_word_addr} <= ~wa;
  endtask : start
  task automatic stop();
    @(posedge clk);
    chip_select_n <= 1'b1;
    output_enable_n <= 1'b1;
  endtask : stop
endmodule : fbrp_host

/* tb/tb_top.sv */
// testbench: host model, array stub and reference burst order
`timescale 1ns/10ps
`include "fbrp_params.svh"
module tb_top;
  import fbrp_pkg::*;
  logic clk, reset_n, wide_bus, id_high_voltage, cfg_write, id_mode, sector_protected;
  logic chip_select_n, output_enable_n, address_valid_n, half_word_addr;
  logic [19:0] address;
  logic [1:0] id_select;
  fbrp_cfg_t cfg_in, cfg_q;
  fbrp_space_t space;
  logic [20:0] array_addr;
  logic [31:0] dq_out, dq_oe;
  logic end_of_burst_n_out, end_of_burst_n_oe, burst_active;
  logic [32:0] beats[$];
  logic [31:0] rnd = 32'h66af8a48;
  int fail_count, num_checks, tick, t_first, lat_ofs = -1;
  fbrp_host i_fbrp_host (.clk(clk), .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
    .address_valid_n(address_valid_n), .address(address), .half_word_addr(half_word_addr));
  fbrp_port i_fbrp_port (.clk(clk), .reset_n(reset_n), .chip_select_n(chip_select_n),
    .output_enable_n(output_enable_n), .address_valid_n(address_valid_n), .wide_bus(wide_bus),
    .address(address), .half_word_addr(half_word_addr), .id_high_voltage(id_high_voltage),
    .cfg_write(cfg_write), .cfg_in(cfg_in), .id_mode(id_mode), .id_select(id_select),
    .sector_protected(sector_protected), .space(space), .array_addr(array_addr),
    .array_data({11'h2a5, array_addr}), .single_data(32'h0f1e2d3c), .dq_out(dq_out), .dq_oe(dq_oe),
    .end_of_burst_n_out(end_of_burst_n_out), .end_of_burst_n_oe(end_of_burst_n_oe), .cfg_q(cfg_q),
    .burst_active(burst_active));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // every driven transfer, with its indicator flag on top
  always @(negedge clk)
  begin
    tick++;
    if (dq_oe[0] === 1'b1 && !output_enable_n)
    begin
      if (beats.size() == 0) t_first = tick;
      beats.push_back({end_of_burst_n_oe, dq_out});
    end
  end
  ////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input string what, input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic wait_beats(input int n);
    int lim;
    lim = 0;
    while (beats.size() < n && lim < 300)
    begin
      @(posedge clk);
      lim++;
    end
    if (lim == 300)
    begin
      check("beat wait", 33'h0, 33'h1);
      give_verdict();
    end
  endtask : wait_beats
  task automatic burst(input logic wide, input logic [2:0] code);
    int n, lat, k;
    logic [20:0] wa, w, e;
    n = 2 << code;
    rnd = lfsr(rnd);
    lat = 2 + rnd[27:24] % 15;
    wa = rnd[20:0];
    w = wide ? (wa >> 1) : wa;
    cfg_in <= '{1'b1, code, lat[4:0]};
    cfg_write <= 1'b1;
    wide_bus <= wide;
    @(posedge clk);
    cfg_write <= 1'b0;
    repeat (3) @(posedge clk);
    beats.delete();
    k = tick;
    i_fbrp_host.start(wa);
    wait_beats(n + 2);
    i_fbrp_host.stop();
    k = t_first - k - lat;
    if (lat_ofs < 0) lat_ofs = k;
    check("latency", 33'(k), 33'(lat_ofs));
    for (k = 0; k < n + 2; k++)
    begin
      e = (w & ~21'(n - 1)) | ((w + 21'(k)) & 21'(n - 1));
      check("eob", 33'(beats[k][32]), 33'(k % n == n - 1));
      check("beat", 33'(beats[k][31:0]), wide ? {1'b0, 11'h2a5, e} : {17'h00000, e[15:0]});
    end
    $display("test burst length code %0d done", code);
  endtask : burst
  ////////////////////
  initial
  begin
    reset_n = 1'b0;
    cfg_write = 1'b0;
    cfg_in = '0;
    id_mode = 1'b0;
    id_select = 2'h0;
    sector_protected = 1'b0;
    space = fbrp_rd_array;
    wide_bus = 1'b0;
    id_high_voltage = 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    check("cfg reset", 33'(cfg_q), 33'h022);
    i_fbrp_host.start(21'h0a5c3);
    repeat (6) @(posedge clk);
    check("async", {dq_oe[0], dq_oe[31:16] | dq_out[31:16], dq_out[15:0]}, {1'b1, 16'h0000, ~16'ha5c3});
    i_fbrp_host.stop();
    $display("test async done");
    sector_protected <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      space <= (i == 0) ? fbrp_rd_ident : fbrp_rd_array;
      id_mode <= i inside {1, 2};
      id_high_voltage <= i > 2;
      id_select <= 2'(i % 3);
      i_fbrp_host.start(~(21'(i - 3) << 1));
      repeat (6) @(posedge clk);
      check("ident", 33'(dq_out[7:0]), 33'(i % 3 == 0 ? `FBRP_ID_MAKER : i % 3 == 1 ? `FBRP_ID_PART : 8'h01));
      i_fbrp_host.stop();
    end
    $display("test ident done");
    id_mode <= 1'b0;
    id_high_voltage <= 1'b0;
    space <= fbrp_rd_single;
    cfg_in <= 9'h122;
    cfg_write <= 1'b1;
    @(posedge clk);
    cfg_write <= 1'b0;
    i_fbrp_host.start(21'h0);
    for (int i = 0; i < 3; i++)
    begin
      repeat (9) @(posedge clk);
      check("single", {dq_oe[0], dq_out}, {1'b1, 32'h00002d3c});
    end
    i_fbrp_host.stop();
    $display("test single done");
    space <= fbrp_rd_array;
    for (int i = 0; i < 6; i++)
      burst(i > 3, 3'(i > 3 ? i - 4 : i + 1));
    beats.delete();
    i_fbrp_host.start(21'h0);
    wait_beats(3);
    i_fbrp_host.stop();
    repeat (5) @(posedge clk);
    check("abort", {end_of_burst_n_oe, dq_oe}, 33'h0);
    burst(1'b0, 3'h2);
    i_fbrp_host.start(21'h0);
    reset_n <= 1'b0;
    @(posedge clk);
    check("reset", {cfg_q.burst_en | end_of_burst_n_oe, dq_oe}, 33'h0);
    reset_n <= 1'b1;
    i_fbrp_host.stop();
    $display("test abort and reset done");
    give_verdict();
  end
endmodule : tb_top
